/* dac_pkg.sv */
// Shared constants for the quad converter two-wire slave and its channel registers.
package dac_pkg;

  // ----------------------------------------
  // Bus addressing
  // ----------------------------------------
  localparam logic [5:0] DEV_ADDR_HI = 6'h06;          // Fixed upper six address bits.
  localparam int         NUM_CH      = 4;              // Number of converter channels.

  // ----------------------------------------
  // Data word layout
  // ----------------------------------------
  localparam int POWER_MODE_HI_POS      = 15;          // Upper power mode bit.
  localparam int POWER_MODE_LO_POS      = 14;          // Lower power mode bit.
  localparam int CLEAR_ALL_N_POS        = 13;          // Active-low clear of every register.
  localparam int LOAD_ALL_OUTPUTS_N_POS = 12;          // Active-low load of every output register.
  localparam int CODE_W                 = 12;          // Width of the data field.
  localparam int DATA_BITS              = 12;          // Resolution in use (8, 10 or 12).

  // Keeps the top DATA_BITS of the data field, the rest read as zero.
  localparam logic [11:0] DATA_MASK = 12'(12'hfff << (CODE_W - DATA_BITS));

  // ----------------------------------------
  // Reset and default values
  // ----------------------------------------
  localparam logic [15:0] READBACK_DEFAULT = 16'h2000; // Only the clear bit set.
  localparam logic [3:0]  POINTER_RESET    = 4'h0;     // No channel selected.

  // ----------------------------------------
  // Power mode codes
  // ----------------------------------------
  localparam logic [1:0] PM_NORMAL   = 2'h0;           // Normal operation.
  localparam logic [1:0] PM_1K_GND   = 2'h1;           // Output to ground through 1 kilohm.
  localparam logic [1:0] PM_100K_GND = 2'h2;           // Output to ground through 100 kilohm.
  localparam logic [1:0] PM_TRISTATE = 2'h3;           // Output left open.

  // Clears the unused low-order data bits of a word.
  function automatic logic [15:0] clean_word(input logic [15:0] w);
    clean_word = {w[15:12], w[11:0] & DATA_MASK};
  endfunction

endpackage

/* pin_sync.sv */
// Two-stage synchroniser for one pin, with edge detection on the safe stage.
module pin_sync
  import dac_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Pin and results.
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic m1;    // First stage, read only by the second.
    logic m2;    // Second stage, safe to use.
    logic prev;  // Delayed copy for edge finding.
  } sync_s;

  sync_s q;
  sync_s d;

  // Shifts the pin through the stages.
  always_comb
  begin
    d      = q;
    d.m1   = pin;
    d.m2   = q.m1;
    d.prev = q.m2;
  end

  // Registers the stages; an idle bus is high.
  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '1;
    else
      q <= d;
  end

  assign level = q.m2;
  assign rise  = q.m2 & ~q.prev;
  assign fall  = ~q.m2 & q.prev;

endmodule

/* dac_channel_bank.sv */
// Input and output registers of the four channels, with clear and load-all.
module dac_channel_bank
  import dac_pkg::*;
(
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Completed write.
  input  wire logic                    commit,
  input  wire logic [3:0]              sel,
  input  wire logic [15:0]             word,
  // Register contents.
  output logic      [3:0][15:0]        in_word,
  output logic      [3:0][CODE_W-1:0]  out_code,
  output logic      [3:0][1:0]         out_mode
);

  typedef struct packed {
    logic [3:0][15:0] in_r;   // Input registers.
    logic [3:0][15:0] out_r;  // Output registers.
    logic [3:0]       dirty;  // Input changed since output last loaded.
  } bank_s;

  bank_s q;
  bank_s d;

  // Applies a completed write to the registers.
  always_comb
  begin
    d = q;
    if (commit)
    begin
      // [R16] clear all registers
      if (!word[CLEAR_ALL_N_POS])
        d = '0;
      else
      begin
        // [R20] same data to selected
        for (int i = 0; i < NUM_CH; i++)
        begin
          if (sel[i])
          begin
            // [R14] unused low data bits cleared
            d.in_r[i]  = clean_word(word);
            d.dirty[i] = 1'b1;
          end
        end
        // [R17] load-all outputs update
        if (!word[LOAD_ALL_OUTPUTS_N_POS])
        begin
          // [R24] copy only changed inputs
          for (int i = 0; i < NUM_CH; i++)
          begin
            if (d.dirty[i])
            begin
              d.out_r[i] = d.in_r[i];
              d.dirty[i] = 1'b0;
            end
          end
        end
      end
    end
  end

  // [R18] power-on zero registers
  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  // Presents codes and modes from the output registers.
  always_comb
  begin
    in_word = q.in_r;
    for (int i = 0; i < NUM_CH; i++)
    begin
      out_code[i] = q.out_r[i][CODE_W-1:0];
      // [R22] mode codes passed to outputs
      out_mode[i] = q.out_r[i][POWER_MODE_HI_POS:POWER_MODE_LO_POS];
    end
  end

  a_clear_zeroes: assert property (@(posedge clk) disable iff (rst) // [R16]
    commit && !word[CLEAR_ALL_N_POS] |=> (q.in_r == '0) && (q.out_r == '0))
    else $error("clear-all did not zero the registers");

  a_outputs_held: assert property (@(posedge clk) disable iff (rst) // [R17]
    commit && word[CLEAR_ALL_N_POS] && word[LOAD_ALL_OUTPUTS_N_POS] |=> q.out_r == $past(q.out_r))
    else $error("output registers changed without load-all");

  a_multi_write: assert property (@(posedge clk) disable iff (rst) // [R20]
    commit && word[CLEAR_ALL_N_POS] && sel[2] && sel[3]
    |=> q.in_r[2] == q.in_r[3] && q.in_r[2] == clean_word($past(word)))
    else $error("selected channels differ after a multi-channel write");

endmodule

/* dac_two_wire_slave.sv */
// Two-wire slave front end of the quad converter: address, pointer, data and readback.

// How it works
// [R1] Answer address 000110 plus select pin.
// [R2] Slave only, never drives the clock.
// [R3] Master opens with start, then address.
// [R4] Acknowledge a matching address on pulse nine.
// [R5] Non-matching address: stay silent, change nothing.
// [R6] Nine pulses per byte, change SDA when low.
// [R7] Master ends transfers with stop.
// [R8] Writes: address, pointer, then data bytes.
// [R9] Pointer read: repeated start, send two bytes.
// [R10] Direct read uses the stored pointer.
// [R11] Pointer bit per channel selects it.
// [R12] Reserved and don't-care pointer bits ignored.
// [R13] Two data bytes form a 16-bit word.
// [R14] Data left justified, unused low bits zero.
// [R15] Mode bits first, then clear and load.
// [R16] Clear bit low zeroes every register.
// [R17] Load bit low updates all outputs.
// [R18] Power-on registers zero until written.
// [R19] Pointer resets to zero, default readback.
// [R20] Several selected channels get same data.
// [R21] Multi-channel readback returns default pattern.
// [R22] Mode codes: normal or three power-downs.
// [R23] Acknowledged read repeats the same two bytes.
// [R24] Load-all copies only changed input registers.
// [R25] Readback matches write format, zeros elsewhere.
// [R26] Aborted write changes no register.
module dac_two_wire_slave
  import dac_pkg::*;
(
  // Clock and reset.
  input  wire logic                   CLK,
  input  wire logic                   RST,
  // Two-wire bus pins.
  input  wire logic                   SCL,
  input  wire logic                   SDA_IN,
  output logic                        SDA_OUT,
  output logic                        SDA_OE,
  // Address strap.
  input  wire logic                   ADDRESS_SELECT_PIN,
  // Converter controls from the output registers.
  output logic      [3:0][CODE_W-1:0] DAC_CODE,
  output logic      [3:0][1:0]        POWER_MODE
);

  // ----------------------------------------
  // Types and state
  // ----------------------------------------
  // Phases of a bus transfer.
  typedef enum logic [3:0] {
    S_IDLE,    // Waiting for a start.
    S_ADDR,    // Shifting in the address byte.
    S_PTR,     // Shifting in the pointer byte.
    S_HI,      // Shifting in the upper data byte.
    S_LO,      // Shifting in the lower data byte.
    S_ACK,     // Holding the acknowledge low.
    S_TX,      // Sending a readback byte.
    S_MACK,    // Waiting for the master's acknowledge.
    S_IGNORE   // Not addressed, or read ended.
  } link_e;

  typedef struct packed {
    link_e       st;      // Current phase.
    link_e       after;   // Phase after the acknowledge.
    logic [3:0]  cnt;     // Bits shifted in or sent.
    logic        full;    // Byte complete, or master acknowledged.
    logic [7:0]  shreg;   // Receive shift register.
    logic [3:0]  ptr;     // Stored channel selects.
    logic [7:0]  hi;      // Upper data byte held for the commit.
    logic [15:0] tx;      // Readback word.
    logic        bsel;    // Readback byte in flight, 1 for the lower.
    logic        oe;      // Pulls SDA low.
    logic        pend;    // Lower byte taken, commit at end of its acknowledge.
    logic        commit;  // One-cycle write completion.
  } eng_s;

  eng_s q;  // Registered engine state.
  eng_s d;  // Next engine state.

  logic             scl_lvl;    // Synchronised clock line.
  logic             scl_rise;   // Clock line rose.
  logic             scl_fall;   // Clock line fell.
  logic             sda_lvl;    // Synchronised data line.
  logic             sda_rise;   // Data line rose.
  logic             sda_fall;   // Data line fell.
  logic             addr_lvl;   // Synchronised address strap.
  logic             start;      // Start or repeated start seen.
  logic             stop;       // Stop seen.
  logic             addr_match; // Received address is ours.
  logic [3:0][15:0] in_words;   // Input register contents.

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Clock line, sampled by the local clock.
  pin_sync u_scl_sync (
    .clk   (CLK),
    .rst   (RST),
    .pin   (SCL),
    .level (scl_lvl),
    .rise  (scl_rise),
    .fall  (scl_fall)
  );

  // Data line, with the same latency as the clock line.
  pin_sync u_sda_sync (
    .clk   (CLK),
    .rst   (RST),
    .pin   (SDA_IN),
    .level (sda_lvl),
    .rise  (sda_rise),
    .fall  (sda_fall)
  );

  // Address strap; edges are of no interest.
  pin_sync u_addr_sync (
    .clk   (CLK),
    .rst   (RST),
    .pin   (ADDRESS_SELECT_PIN),
    .level (addr_lvl),
    .rise  (),
    .fall  ()
  );

  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  // [R3] start and stop detection
  assign start = sda_fall & scl_lvl;
  assign stop  = sda_rise & scl_lvl;

  // [R1] fixed bits plus strap
  assign addr_match = (q.shreg[7:1] == {DEV_ADDR_HI, addr_lvl});

  // ----------------------------------------
  // Readback
  // ----------------------------------------
  // Picks the word of the single selected channel, or the default pattern.
  function automatic logic [15:0] readback(input logic [3:0] sel, input logic [3:0][15:0] w);
    case (sel)
      4'h1:    readback = clean_word(w[0]);
      4'h2:    readback = clean_word(w[1]);
      4'h4:    readback = clean_word(w[2]);
      4'h8:    readback = clean_word(w[3]);
      // [R21] none or several: default pattern
      default: readback = READBACK_DEFAULT;
    endcase
  endfunction

  // Bit of the readback word to send, msb of each byte first.
  function automatic logic tx_bit(input logic [15:0] w, input logic bsel, input logic [3:0] cnt);
    logic [7:0] b;
    b      = bsel ? w[7:0] : w[15:8];
    tx_bit = b[3'(7 - cnt)];
  endfunction

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  // Works out the next engine state from the bus events.
  always_comb
  begin
    d        = q;
    d.commit = 1'b0;
    if (start)
    begin
      // A start restarts the byte count from any phase; the pointer is kept.
      d.st   = S_ADDR;
      d.cnt  = 4'h0;
      d.full = 1'b0;
      d.oe   = 1'b0;
      d.pend = 1'b0;
    end
    else if (stop)
    begin
      // [R26] stop before commit drops data
      d.st   = S_IDLE;
      d.oe   = 1'b0;
      d.full = 1'b0;
      d.pend = 1'b0;
    end
    else
    begin
      case (q.st)
        S_ADDR, S_PTR, S_HI, S_LO:
        begin
          // [R6] sample while clock high
          if (scl_rise && !q.full)
          begin
            d.shreg = {q.shreg[6:0], sda_lvl};
            if (q.cnt == 4'h7)
              d.full = 1'b1;
            else
              d.cnt = q.cnt + 4'h1;
          end
          else if (scl_fall && q.full)
          begin
            // Eighth bit done: acknowledge during the ninth pulse.
            d.full = 1'b0;
            d.cnt  = 4'h0;
            d.oe   = 1'b1;
            d.st   = S_ACK;
            case (q.st)
              S_ADDR:
              begin
                // [R4] acknowledge matching address
                if (addr_match)
                begin
                  // [R10] read uses stored pointer
                  d.after = q.shreg[0] ? S_TX : S_PTR;
                  d.tx    = readback(q.ptr, in_words);
                end
                else
                begin
                  // [R5] stay off the bus
                  d.oe = 1'b0;
                  d.st = S_IGNORE;
                end
              end
              S_PTR:
              begin
                // [R11] channel selects stored
                d.ptr   = q.shreg[3:0];
                d.after = S_HI;
              end
              S_HI:
              begin
                // [R13] upper byte held
                d.hi    = q.shreg;
                d.after = S_LO;
              end
              default:
              begin
                // Lower byte: commit once its acknowledge ends, then accept more pairs.
                d.pend  = 1'b1;
                d.after = S_HI;
              end
            endcase
          end
        end
        S_ACK:
        begin
          // Release the line at the end of the ninth pulse.
          if (scl_fall)
          begin
            d.oe     = 1'b0;
            d.st     = q.after;
            d.commit = q.pend;
            d.pend   = 1'b0;
            d.bsel   = 1'b0;
            // [R9] first readback bit
            if (q.after == S_TX)
            begin
              d.oe  = ~q.tx[15];
              d.cnt = 4'h1;
            end
          end
        end
        S_TX:
        begin
          // [R25] send word bits msb first
          if (scl_fall)
          begin
            if (q.cnt == 4'h8)
            begin
              d.oe   = 1'b0;
              d.st   = S_MACK;
              d.full = 1'b0;
            end
            else
            begin
              d.oe  = ~tx_bit(q.tx, q.bsel, q.cnt);
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
        S_MACK:
        begin
          // The master's low answer on the ninth pulse asks for more.
          if (scl_rise)
            d.full = ~sda_lvl;
          else if (scl_fall)
          begin
            if (q.full)
            begin
              // [R23] repeat the same bytes
              d.bsel = ~q.bsel;
              d.st   = S_TX;
              d.oe   = ~tx_bit(q.tx, ~q.bsel, 4'h0);
              d.cnt  = 4'h1;
              d.full = 1'b0;
            end
            else
              d.st = S_IGNORE;
          end
        end
        default:
        begin
          // Idle or ignoring: wait for the next start.
          d.oe = 1'b0;
        end
      endcase
    end
  end

  // [R19] pointer resets to zero
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      q     <= '0;
      q.st  <= S_IDLE;
      q.ptr <= POINTER_RESET;
    end
    else
      q <= d;
  end

  // ----------------------------------------
  // Channel registers
  // ----------------------------------------
  // [R15] word holds mode, clear, load
  dac_channel_bank u_bank (
    .clk      (CLK),
    .rst      (RST),
    .commit   (q.commit),
    .sel      (q.ptr),
    .word     ({q.hi, q.shreg}),
    .in_word  (in_words),
    .out_code (DAC_CODE),
    .out_mode (POWER_MODE)
  );

  // [R2] open-drain data only
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = q.oe;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_ack_on_match: assert property (@(posedge CLK) disable iff (RST) // [R4]
    q.st == S_ADDR && q.full && scl_fall && addr_match && !start && !stop |=> SDA_OE && q.st == S_ACK)
    else $error("matching address not acknowledged");
  a_ignore_silent: assert property (@(posedge CLK) disable iff (RST) // [R5]
    q.st == S_IGNORE |-> !SDA_OE && !q.commit)
    else $error("device active while not addressed");
  a_sda_scl_low: assert property (@(posedge CLK) disable iff (RST) // [R6]
    $changed(SDA_OE) && !$past(start) && !$past(stop) |-> !scl_lvl)
    else $error("SDA changed while SCL high");
  a_ptr_reset: assert property (@(posedge CLK) // [R19]
    $fell(RST) |-> q.ptr == POINTER_RESET)
    else $error("pointer not zero after reset");
  a_ptr_kept: assert property (@(posedge CLK) disable iff (RST) // [R10]
    start |=> q.ptr == $past(q.ptr))
    else $error("pointer lost at a start");
  a_default_read: assert property (@(posedge CLK) disable iff (RST) // [R21]
    q.st == S_ADDR && q.full && scl_fall && addr_match && q.shreg[0] && !$onehot(q.ptr) && !start && !stop
    |=> q.tx == READBACK_DEFAULT)
    else $error("multi or no channel readback not default");
  a_repeat_word: assert property (@(posedge CLK) disable iff (RST) // [R23]
    q.st == S_MACK && q.full && q.bsel && scl_fall && !start && !stop |=> q.st == S_TX && !q.bsel && $stable(q.tx))
    else $error("readback did not restart the same word");
  a_commit_full: assert property (@(posedge CLK) disable iff (RST) // [R26]
    q.commit |-> $past(q.st) == S_ACK && $past(q.pend) && $past(q.after) == S_HI)
    else $error("commit without two acknowledged data bytes");
endmodule

/* two_wire_master.sv */
// Behavioural two-wire bus master that drives the converter's bus lines.
module two_wire_master
(
  // Clock used only to pick a start phase.
  input  wire logic clk,
  // Bus lines.
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_wire
);
  timeunit 1ns;
  timeprecision 100ps;

  // Both lines idle high; the clock stands still outside frames.
  initial
  begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // Data changes low.
  // One bit in 48 ns: data moves while the clock is low, sampled while high.
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    #12;
    scl = 1'b1;
    #12;
    r = sda_wire;
    #12;
    scl = 1'b0;
    #12;
  endtask

  // Start condition.
  // Also serves as a repeated start; begins off the clock grid.
  task automatic start();
    @(negedge clk);
    sda_drv = 1'b1;
    #12;
    scl = 1'b1;
    #12;
    sda_drv = 1'b0;
    #12;
    scl = 1'b0;
    #12;
  endtask

  // Eight bits, acknowledge.
  // Sends a byte MSB first, then releases the line to read the acknowledge.
  task automatic tx_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, ack);
  endtask

  // Read one byte, then acknowledge.
  // Receives a byte, then answers with the given acknowledge level.
  task automatic rx_byte(input logic ack_out, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(ack_out, r);
  endtask

  // Stop condition.
  // Data pulled low while the clock is low, then raised while it is high.
  task automatic stop();
    sda_drv = 1'b0;
    #12;
    scl = 1'b1;
    #12;
    sda_drv = 1'b1;
    #24;
  endtask
endmodule

/* tb_dac_two_wire_slave.sv */
// Self-checking bench for the quad converter two-wire slave.
module tb_dac_two_wire_slave
  import dac_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int LIMIT = 40000;       // Cycle ceiling for the whole run.
  logic                   clk = 1'b0; // System clock.
  logic                   rst;        // Synchronous reset.
  logic                   a0;         // Address strap.
  logic                   m_scl;      // Bus clock from the master.
  logic                   m_sda;      // Master's data drive, high is released.
  wire                    sda_wire;   // Resolved data line.
  logic                   sda_out;    // Device data value.
  logic                   sda_oe;     // Device pulls the line.
  logic [3:0][CODE_W-1:0] dac_code;   // Output register codes.
  logic [3:0][1:0]        power_mode; // Output register modes.
  int                     n_errors;   // Mismatches seen.
  int                     checks;     // Comparisons made.
  int                     cycles = 0; // Clock cycles run.
  logic [15:0]            w;          // Word read back.
  logic [15:0]            w2;         // Second word read back.
  logic                   ack;        // Acknowledge level seen.

  // Open-drain line with pull-up: low if either party pulls it.
  assign sda_wire = (sda_oe ? sda_out : 1'b1) & m_sda;

  // ----------------------------------------
  // Instances
  // ----------------------------------------
  dac_two_wire_slave DUT (
    .CLK                (clk),
    .RST                (rst),
    .SCL                (m_scl),
    .SDA_IN             (sda_wire),
    .SDA_OUT            (sda_out),
    .SDA_OE             (sda_oe),
    .ADDRESS_SELECT_PIN (a0),
    .DAC_CODE           (dac_code),
    .POWER_MODE         (power_mode)
  );

  two_wire_master m (
    .clk      (clk),
    .scl      (m_scl),
    .sda_drv  (m_sda),
    .sda_wire (sda_wire)
  );

  // ----------------------------------------
  // Checking and ending
  // ----------------------------------------
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Compares one 16-bit result.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compares one channel's output mode and code.
  task automatic chk_out(input int ch, input logic [1:0] md, input logic [11:0] code);
    chk({2'h0, power_mode[ch], dac_code[ch]}, {2'h0, md, code});
  endtask

  // Write: address, pointer, then nb data bytes of wd, then stop.
  task automatic wr(input logic [7:0] ptr, input logic [15:0] wd, input int nb);
    logic a;
    m.start();
    m.tx_byte({DEV_ADDR_HI, a0, 1'b0}, a);
    chk({15'h0, a}, 16'h0000);
    m.tx_byte(ptr, a);
    chk({15'h0, a}, 16'h0000);
    if (nb > 0)
      m.tx_byte(wd[15:8], a);
    if (nb > 1)
      m.tx_byte(wd[7:0], a);
    m.stop();
    repeat (4) @(posedge clk);
  endtask

  // Read: optional pointer and repeated start, then two bytes.
  task automatic rd(input logic with_ptr, input logic [7:0] ptr, output logic [15:0] rw);
    logic a;
    m.start();
    if (with_ptr)
    begin
      m.tx_byte({DEV_ADDR_HI, a0, 1'b0}, a);
      m.tx_byte(ptr, a);
      m.start();
    end
    m.tx_byte({DEV_ADDR_HI, a0, 1'b1}, a);
    chk({15'h0, a}, 16'h0000);
    m.rx_byte(1'b0, rw[15:8]);
    m.rx_byte(1'b1, rw[7:0]);
    m.stop();
  endtask

  // Clock and hang guard.
  always #2.5 clk = ~clk;

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      n_errors++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst      = 1'b1;
    a0       = 1'b0;
    n_errors = 0;
    checks   = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // Power-on state and default readback with no pointer written.
    for (int i = 0; i < 4; i++)
      chk_out(i, PM_NORMAL, 12'h000);
    rd(1'b0, 8'h00, w);
    chk(w, READBACK_DEFAULT);
    // Foreign address: no acknowledge, a would-be load is ignored.
    m.start();
    m.tx_byte({DEV_ADDR_HI, 1'b1, 1'b0}, ack);
    chk({15'h0, ack}, 16'h0001);
    m.tx_byte(8'h0f, ack);
    m.tx_byte(8'h2a, ack);
    m.tx_byte(8'hbc, ack);
    m.stop();
    repeat (4) @(posedge clk);
    chk_out(0, PM_NORMAL, 12'h000);
    // Held load: input changes, output does not; readback shows the word.
    wr(8'h01, 16'h3abc, 2);
    chk_out(0, PM_NORMAL, 12'h000);
    rd(1'b1, 8'h01, w);
    chk(w, 16'h3abc);
    // Every mode code; the last write loads all outputs at once.
    for (int i = 0; i < 4; i++)
      wr(8'h01 << i, {2'(i), 1'b1, (i != 3), 8'h80, 4'(i)}, 2);
    for (int i = 0; i < 4; i++)
      chk_out(i, 2'(i), {8'h80, 4'(i)});
    // Same word into two channels; multi-channel readback is the default.
    wr(8'h0c, 16'h65a5, 2);
    chk_out(2, PM_1K_GND, 12'h5a5);
    chk_out(3, PM_1K_GND, 12'h5a5);
    chk_out(0, PM_NORMAL, 12'h800);
    rd(1'b1, 8'h06, w);
    chk(w, READBACK_DEFAULT);
    // A single-channel pointer read leaves channel D in the stored pointer.
    rd(1'b1, 8'h08, w);
    chk(w, 16'h65a5);
    // Direct read of the stored pointer, acknowledged to repeat.
    m.start();
    m.tx_byte({DEV_ADDR_HI, a0, 1'b1}, ack);
    chk({15'h0, ack}, 16'h0000);
    m.rx_byte(1'b0, w[15:8]);
    m.rx_byte(1'b0, w[7:0]);
    m.rx_byte(1'b0, w2[15:8]);
    m.rx_byte(1'b1, w2[7:0]);
    m.stop();
    chk(w, 16'h65a5);
    chk(w2, 16'h65a5);
    // Write cut after one data byte; a clear would follow if committed.
    wr(8'h01, 16'h0fff, 1);
    rd(1'b1, 8'h01, w);
    chk(w, 16'h3800);
    chk_out(0, PM_NORMAL, 12'h800);
    // Clear bit low zeroes every input and output register.
    wr(8'h02, 16'h1123, 2);
    for (int i = 0; i < 4; i++)
      chk_out(i, PM_NORMAL, 12'h000);
    rd(1'b1, 8'h02, w);
    chk(w, 16'h0000);
    // Strap high moves the address low bit.
    @(posedge clk);
    a0 <= 1'b1;
    repeat (8) @(posedge clk);
    wr(8'h01, 16'h2fff, 2);
    chk_out(0, PM_NORMAL, 12'hfff);
    complete_run();
  end
endmodule
